// [design/tgmc_defs.svh]
// Purpose: Offsets, field positions and reset values of the control bank.
// Assumes: Included by bare name from the package users.
// Notes:   Offsets are byte addresses on the register bus.
`ifndef TGMC_DEFS_SVH
`define TGMC_DEFS_SVH

`define TGMC_OFF_MCTRL   16'h0000
`define TGMC_OFF_SCTRL   16'h0004
`define TGMC_OFF_ESTAT   16'h0008
`define TGMC_OFF_EEN     16'h000C
`define TGMC_OFF_EMASK   16'h0010
`define TGMC_OFF_CFG     16'h0014
`define TGMC_OFF_PROBE   16'h00B4
`define TGMC_OFF_WRCMD   16'h1000
`define TGMC_OFF_RDCMD   16'h2000

`define TGMC_BIT_RUN     20
`define TGMC_BIT_LOOP    19
`define TGMC_BIT_DONE    31

`define TGMC_SCTRL_MASK  32'h000F8000
`define TGMC_EEN_MASK    32'h801F0003
`define TGMC_EEN_RESET   32'h80000000
`define TGMC_ERR_MASK    32'h001F0003

`define TGMC_ENT_VALID   31
`define TGMC_ENT_OWNDEP  30
`define TGMC_ENT_OTHDEP  29

`endif

// [design/tgmc_pkg.sv]
// Purpose: Types shared by the control bank and its channel sequencers.
// Assumes: Nothing beyond the defines header.
// Notes:   State codes follow a Gray path.
`default_nettype none

package tgmc_pkg;

  typedef logic [31:0] tgmc_word_t;

  typedef enum logic [2:0] {
    BUS_IDLE   = 3'h0,
    BUS_WRITE  = 3'h1,
    BUS_RDWAIT = 3'h3,
    BUS_RDLAST = 3'h2,
    BUS_ERR1   = 3'h6,
    BUS_ERR2   = 3'h7
  } tgmc_bus_e;

  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'h0,
    SEQ_FETCH = 3'h1,
    SEQ_CHECK = 3'h3,
    SEQ_ISSUE = 3'h2,
    SEQ_DRAIN = 3'h6
  } tgmc_seq_e;

endpackage : tgmc_pkg

`default_nettype wire

// [design/tgmc_cmd_mem.sv]
// Purpose: Command store of one channel, one write and one read port.
// Assumes: Software fills it before the run is started.
// Notes:   Read data come out of a register, one cycle after the address.
`default_nettype none

module tgmc_cmd_mem
#(
  parameter int AW = 4
)
(
  input  wire logic                 sys_clk,
  input  wire logic                 wrEn,
  input  wire logic [AW-1:0]        wrAddr,
  input  wire tgmc_pkg::tgmc_word_t wrData,
  input  wire logic [AW-1:0]        rdAddr,
  output var  tgmc_pkg::tgmc_word_t rdData
);
  import tgmc_pkg::*;

  tgmc_word_t store [2**AW];

  always_ff @(posedge sys_clk)
  begin
    if (wrEn)
      store[wrAddr] <= wrData;
  end

  always_ff @(posedge sys_clk)
  begin
    rdData <= store[rdAddr];
  end

endmodule : tgmc_cmd_mem

`default_nettype wire

// [design/tgmc_chan_seq.sv]
// Purpose: Walks one channel's command store and hands commands out.
// Assumes: Entry data arrive one cycle after the entry address.
// Notes:   Completions left over from an earlier pass count in the next.
`include "tgmc_defs.svh"
`default_nettype none

module tgmc_chan_seq
#(
  parameter int IDX_W = 4
)
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic                 start,
  input  wire logic                 loopEnable,
  input  wire tgmc_pkg::tgmc_word_t entry,
  output logic [IDX_W-1:0]          entryAddr,
  output logic                      cmdValid,
  input  wire logic                 cmdReady,
  output var  tgmc_pkg::tgmc_word_t cmdData,
  input  wire logic                 cmdCompleted,
  input  wire logic                 engineIdle,
  input  wire logic [IDX_W:0]       otherDone,
  output logic [IDX_W:0]            ownDone,
  output logic                      finished
);
  import tgmc_pkg::*;

  tgmc_seq_e        state;
  tgmc_seq_e        next_state;
  logic [IDX_W-1:0] idx;
  logic [IDX_W:0]   depIdx;
  logic             waitDep;
  logic             restart;

  assign depIdx    = {1'b0, entry[IDX_W-1:0]};
  // Checked when the command is reached, so a clear after it ran has no effect.
  assign waitDep   = !loopEnable && ((entry[`TGMC_ENT_OWNDEP] && ownDone <= depIdx) ||
                     (entry[`TGMC_ENT_OTHDEP] && otherDone <= depIdx));
  // With looping on, the end marker sends the channel straight back to its first command.
  assign restart   = (state == SEQ_CHECK) && !entry[`TGMC_ENT_VALID] && loopEnable;
  assign entryAddr = idx;
  assign cmdValid  = (state == SEQ_ISSUE);
  assign finished  = (state == SEQ_DRAIN) && engineIdle;

  always_comb
  begin
    next_state = state;
    unique case (state)
      SEQ_IDLE:  if (start) next_state = SEQ_FETCH;
      SEQ_FETCH: next_state = SEQ_CHECK;
      SEQ_CHECK:
      begin
        if (!entry[`TGMC_ENT_VALID])
          next_state = loopEnable ? SEQ_FETCH : SEQ_DRAIN;
        else if (!waitDep)
          next_state = SEQ_ISSUE;
      end
      SEQ_ISSUE: if (cmdReady) next_state = SEQ_FETCH;
      SEQ_DRAIN: if (engineIdle) next_state = SEQ_IDLE;
      default:   next_state = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state <= SEQ_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || state == SEQ_IDLE || restart)
      idx <= '0;
    else if (cmdValid && cmdReady)
      idx <= idx + 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || (state == SEQ_IDLE && start) || restart)
      ownDone <= '0;
    else if (cmdCompleted)
      ownDone <= ownDone + 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cmdData <= '0;
    else if (state == SEQ_CHECK && next_state == SEQ_ISSUE)
      cmdData <= entry;
  end

endmodule : tgmc_chan_seq

`default_nettype wire

// [design/tgmc_top.sv]
// Purpose: Register bank and master control of a bus traffic generator.
// Assumes: AHB-Lite single word transfers; one clock, synchronous reset.
// Notes:   Command engines sit outside and talk over the command ports.
//
// Decided for this implementation: the AHB-Lite register port.
`include "tgmc_defs.svh"
`default_nettype none

// Summary of operation
// - Registers exist only in full-protocol mode.
// - Master control at 0x00, slave control 0x04.
// - Error status, enable, interrupt mask at 0x08-0x10.
// - Configuration status register at 0x14.
// - In full-protocol mode, any access to 0xB4 answers ERROR.
// - Read-only revision in master control 31:24.
// - Read-only ID width code in bits 23:21.
// - Software sets run enable; traffic starts.
// - Run enable self-clears when both channels finish.
// - Loop enable replays the command set forever.
// - Clearing loop finishes current set, then stops.
// - Dependencies ignored while looping is on.
// - Channels restart independently, not waiting outstanding.
// - Shorter channel keeps repeating its own set.
// - Final pass honours dependencies not yet passed.
// - Completion interrupt after the final set.
// - Read-only registers answer OKAY.
// - Done interrupt gated by enable, resets one.
module tgmc_top
#(
  parameter bit         FULL_MODE      = 1'b1,
  parameter int         MASTER_ID_BITS = 1,
  parameter int         IDX_W          = 4,
  // Value is arbitrary.
  parameter logic [7:0] REVISION       = 8'h5A
)
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic                 hsel,
  input  wire logic [15:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire tgmc_pkg::tgmc_word_t hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output var  tgmc_pkg::tgmc_word_t hrdata,
  output logic                      wrCmdValid,
  input  wire logic                 wrCmdReady,
  output var  tgmc_pkg::tgmc_word_t wrCmdData,
  input  wire logic                 wrCmdCompleted,
  input  wire logic                 wrEngineIdle,
  output logic                      rdCmdValid,
  input  wire logic                 rdCmdReady,
  output var  tgmc_pkg::tgmc_word_t rdCmdData,
  input  wire logic                 rdCmdCompleted,
  input  wire logic                 rdEngineIdle,
  input  wire tgmc_pkg::tgmc_word_t errEvent,
  output logic                      doneIrq,
  output logic                      errIrq
);
  import tgmc_pkg::*;

  // ------------------------------------------------------------
  // Constants
  // ------------------------------------------------------------

  localparam logic [2:0] ID_CODE =
    (MASTER_ID_BITS <= 1) ? 3'h0 : 3'(MASTER_ID_BITS - 1);

  localparam tgmc_word_t CFG_WORD =
    {15'h0000, FULL_MODE, 8'(IDX_W), 8'(MASTER_ID_BITS)};

  localparam logic [15:0] WIN_BASE [2] = '{`TGMC_OFF_WRCMD, `TGMC_OFF_RDCMD};

  // Upper address bits pick the store; the index aliases above the depth.
  function automatic logic inWindow
  (
    input logic [15:0] addr,
    input logic [15:0] base
  );
    return addr[15:12] == base[15:12];
  endfunction : inWindow

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------

  tgmc_bus_e      busState;
  tgmc_bus_e      next_busState;
  logic [15:0]    dpAddr;
  logic           accept;
  logic           wrStrobe;
  logic           wMctrl;
  logic           wSctrl;
  logic           wEstat;
  logic           wEen;
  logic           wEmask;
  tgmc_word_t     readValue;

  logic           runEnable;
  logic           loopEnable;
  tgmc_word_t     slaveCtrl;
  tgmc_word_t     errStat;
  tgmc_word_t     errEn;
  tgmc_word_t     errMask;
  tgmc_word_t     estSet;
  tgmc_word_t     estClr;
  logic [1:0]     finFlag;
  logic           startReq;
  logic           doneNow;

  logic [1:0]     memWe;
  logic [1:0]     cmdValid;
  logic [1:0]     cmdReady;
  logic [1:0]     cmdCompleted;
  logic [1:0]     engineIdle;
  logic [1:0]     finished;
  tgmc_word_t     cmdData [2];
  logic [IDX_W:0] doneCnt [2];

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------

  assign accept = hsel && htrans[1] && hready;

  always_comb
  begin
    next_busState = BUS_IDLE;
    unique case (busState)
      BUS_RDWAIT: next_busState = BUS_RDLAST;
      BUS_ERR1:   next_busState = BUS_ERR2;
      default:
      begin
        if (accept && FULL_MODE && haddr == `TGMC_OFF_PROBE)
          next_busState = BUS_ERR1;
        else if (accept && hwrite)
          next_busState = BUS_WRITE;
        else if (accept)
          next_busState = BUS_RDWAIT;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      busState <= BUS_IDLE;
    else
      busState <= next_busState;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      dpAddr <= '0;
    else if (accept)
      dpAddr <= haddr;
  end

  // Reads take one wait state so that a read right behind a write sees it.
  assign hreadyout = (busState != BUS_RDWAIT) && (busState != BUS_ERR1);
  // Two-cycle error answer; every other access answers OKAY.
  assign hresp     = (busState == BUS_ERR1) || (busState == BUS_ERR2);

  // The transfer size is not looked at: every write lands as a full word.
  assign wrStrobe = (busState == BUS_WRITE) && FULL_MODE;
  assign wMctrl   = wrStrobe && dpAddr == `TGMC_OFF_MCTRL;
  assign wSctrl   = wrStrobe && dpAddr == `TGMC_OFF_SCTRL;
  assign wEstat   = wrStrobe && dpAddr == `TGMC_OFF_ESTAT;
  assign wEen     = wrStrobe && dpAddr == `TGMC_OFF_EEN;
  assign wEmask   = wrStrobe && dpAddr == `TGMC_OFF_EMASK;

  always_comb
  begin
    readValue = '0;
    if (FULL_MODE)
    begin
      case (dpAddr)
        `TGMC_OFF_MCTRL:
          readValue = {REVISION, ID_CODE, runEnable, loopEnable, 19'h00000};
        `TGMC_OFF_SCTRL: readValue = slaveCtrl;
        `TGMC_OFF_ESTAT: readValue = errStat;
        `TGMC_OFF_EEN:   readValue = errEn;
        `TGMC_OFF_EMASK: readValue = errMask;
        `TGMC_OFF_CFG:   readValue = CFG_WORD;
        default:         readValue = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      hrdata <= '0;
    else if (busState == BUS_RDWAIT)
      hrdata <= readValue;
  end

  // ------------------------------------------------------------
  // Master control
  // ------------------------------------------------------------

  assign startReq = wMctrl && hwdata[`TGMC_BIT_RUN] && !runEnable;
  assign doneNow  = runEnable && (finFlag == 2'h3);

  // Software can only set the run bit; clearing it mid-run would strand the channels.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      runEnable <= 1'b0;
    else if (doneNow)
      runEnable <= 1'b0;
    else if (wMctrl)
      runEnable <= runEnable | hwdata[`TGMC_BIT_RUN];
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      loopEnable <= 1'b0;
    else if (wMctrl)
      loopEnable <= hwdata[`TGMC_BIT_LOOP];
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst || startReq)
      finFlag <= 2'h0;
    else
      finFlag <= finFlag | finished;
  end

  // ------------------------------------------------------------
  // Error and configuration registers
  // ------------------------------------------------------------

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      slaveCtrl <= '0;
    else if (wSctrl)
      slaveCtrl <= hwdata & `TGMC_SCTRL_MASK;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      errEn <= `TGMC_EEN_RESET;
    else if (wEen)
      errEn <= hwdata & `TGMC_EEN_MASK;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      errMask <= '0;
    else if (wEmask)
      errMask <= hwdata & `TGMC_ERR_MASK;
  end

  always_comb
  begin
    estSet = errEvent & errEn & `TGMC_ERR_MASK;
    estSet[`TGMC_BIT_DONE] = doneNow && errEn[`TGMC_BIT_DONE];
    estClr = wEstat ? hwdata : '0;
  end

  // A new event in the clearing cycle survives the clear.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      errStat <= '0;
    else
      errStat <= (errStat & ~estClr) | estSet;
  end

  assign doneIrq = errStat[`TGMC_BIT_DONE];
  assign errIrq  = |(errStat & errMask & `TGMC_ERR_MASK);

  // ------------------------------------------------------------
  // Channels: 0 is write, 1 is read
  // ------------------------------------------------------------

  assign cmdReady     = {rdCmdReady, wrCmdReady};
  assign cmdCompleted = {rdCmdCompleted, wrCmdCompleted};
  assign engineIdle   = {rdEngineIdle, wrEngineIdle};
  assign wrCmdValid   = cmdValid[0];
  assign rdCmdValid   = cmdValid[1];
  assign wrCmdData    = cmdData[0];
  assign rdCmdData    = cmdData[1];

  for (genvar ch = 0; ch < 2; ch++)
  begin : g_chan
    tgmc_word_t       entry;
    logic [IDX_W-1:0] entryAddr;

    assign memWe[ch] = wrStrobe && inWindow(dpAddr, WIN_BASE[ch]);

    tgmc_cmd_mem #(
      .AW (IDX_W)
    ) u_mem (
      .sys_clk (sys_clk),
      .wrEn    (memWe[ch]),
      .wrAddr  (dpAddr[IDX_W+1:2]),
      .wrData  (hwdata),
      .rdAddr  (entryAddr),
      .rdData  (entry)
    );

    tgmc_chan_seq #(
      .IDX_W (IDX_W)
    ) u_seq (
      .sys_clk      (sys_clk),
      .rst          (rst),
      .start        (startReq),
      .loopEnable   (loopEnable),
      .entry        (entry),
      .entryAddr    (entryAddr),
      .cmdValid     (cmdValid[ch]),
      .cmdReady     (cmdReady[ch]),
      .cmdData      (cmdData[ch]),
      .cmdCompleted (cmdCompleted[ch]),
      .engineIdle   (engineIdle[ch]),
      .otherDone    (doneCnt[1-ch]),
      .ownDone      (doneCnt[ch]),
      .finished     (finished[ch])
    );
  end

endmodule : tgmc_top

`default_nettype wire

// [testbench/tgmc_top_asserts.sv]
// Purpose: Concurrent checks on the register bus and command ports of the control bank.
// Assumes: One clock domain; hready is the bank's own hreadyout.
// Notes:   Bound into the top module after the module below.
`default_nettype none

module tgmc_top_asserts
(
  input wire logic                 sys_clk,
  input wire logic                 rst,
  input wire logic                 hsel,
  input wire logic [15:0]          haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic                 hready,
  input wire logic                 hreadyout,
  input wire logic                 hresp,
  input wire logic                 wrCmdValid,
  input wire logic                 wrCmdReady,
  input wire tgmc_pkg::tgmc_word_t wrCmdData,
  input wire logic                 rdCmdValid,
  input wire logic                 rdCmdReady,
  input wire tgmc_pkg::tgmc_word_t rdCmdData,
  input wire logic                 wrEngineIdle,
  input wire logic                 rdEngineIdle,
  input wire logic                 doneIrq
);
  timeunit 1ns;
  timeprecision 1ns;
  import tgmc_pkg::*;

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  logic acc;
  assign acc = hsel && htrans[1] && hready;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_PROBE_ERR: assert property (acc && haddr == 16'h00B4 |=> hresp && !hreadyout ##1 hresp && hreadyout)
    else $error("Probe offset did not give the two-cycle error answer.");
  AST_HRESP_CAUSE: assert property ($rose(hresp) |-> $past(acc) && $past(haddr) == 16'h00B4)
    else $error("Error answer without a probe access.");
  AST_READ_WAIT: assert property (acc && !hwrite && haddr != 16'h00B4 |=> !hreadyout && !hresp ##1 hreadyout && !hresp)
    else $error("Read did not take one wait and answer OKAY.");
  AST_WRITE_ZERO_WAIT: assert property (acc && hwrite && haddr != 16'h00B4 |=> hreadyout && !hresp)
    else $error("Write did not finish at once with OKAY.");
  AST_DONE_WHEN_IDLE: assert property ($rose(doneIrq) |-> $past(wrEngineIdle) && $past(rdEngineIdle))
    else $error("Completion flagged while an engine was busy.");
  AST_WR_HOLD: assert property (wrCmdValid && !wrCmdReady |=> wrCmdValid && $stable(wrCmdData))
    else $error("Write command dropped or changed before it was taken.");
  AST_RD_GAP: assert property (rdCmdValid && rdCmdReady |=> !rdCmdValid [*2])
    else $error("Read commands offered closer than the fetch spacing.");
  AST_ENTRY_VALID: assert property (wrCmdValid || rdCmdValid |-> (!wrCmdValid || wrCmdData[31]) && (!rdCmdValid || rdCmdData[31]))
    else $error("An invalid entry was offered as a command.");
endmodule : tgmc_top_asserts

bind tgmc_top tgmc_top_asserts tgmc_top_asserts_inst (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .wrCmdValid, .wrCmdReady, .wrCmdData, .rdCmdValid, .rdCmdReady, .rdCmdData, .wrEngineIdle,
  .rdEngineIdle, .doneIrq);

`default_nettype wire

// [testbench/tgmc_engine_model.sv]
// Purpose: Behavioural command engine that takes commands and reports completions.
// Assumes: Commands are taken on an edge with valid and ready both high.
// Notes:   Ready and completion timing are random, so loops overlap outstanding work.
`default_nettype none

module tgmc_engine_model
(
  input  wire logic   sys_clk,
  input  wire logic   rst,
  input  wire logic   cmdValid,
  output logic        cmdReady,
  output logic        cmdCompleted,
  output logic        engineIdle,
  output logic [15:0] cmdCount
);
  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------------------------
  // Engine
  // ---------------------------------------------------------------
  logic [7:0] pending;
  logic       take;
  logic       fin;

  assign engineIdle = (pending == 8'h00);

  always @(posedge sys_clk)
  begin
    take = cmdValid && cmdReady;
    fin  = (pending != 8'h00) && ($urandom_range(1) == 0);
    if (rst)
    begin
      cmdReady     <= 1'b0;
      cmdCompleted <= 1'b0;
      pending      <= 8'h00;
      cmdCount     <= 16'h0000;
    end
    else
    begin
      // A stalled ready lets the sequencer show that it holds its offer.
      cmdReady     <= ($urandom_range(2) != 0);
      cmdCompleted <= fin;
      pending      <= pending + 8'(take) - 8'(fin);
      cmdCount     <= cmdCount + 16'(take);
    end
  end
endmodule : tgmc_engine_model

`default_nettype wire

// [testbench/tb_tgmc_top.sv]
// Purpose: Self-checking bench for the control bank over AHB-Lite with two engine models.
// Assumes: Default full-protocol mode; seed 77 makes the run repeatable.
// Notes:   Bus answers are sampled at the rising edge that ends each phase.
`include "tgmc_defs.svh"
`default_nettype none

module tb_tgmc_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tgmc_pkg::*;

  // ---------------------------------------------------------------
  // Signals and helpers
  // ---------------------------------------------------------------
  localparam logic [7:0] CORE_REVISION_FIELD = 8'hC3; // Value is arbitrary.
  localparam int         IDB = 4;
  localparam tgmc_word_t CFG = {15'h0, 1'b1, 8'h04, 8'(IDB)};
  logic       sys_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [15:0] haddr = 16'h0000, wrCount, rdCount;
  logic [1:0]  htrans = 2'h0;
  tgmc_word_t  hwdata = '0, errEvent = '0, hrdata, wrCmdData, rdCmdData;
  logic        hready, hreadyout, hresp, wrCmdValid, wrCmdReady, wrCmdCompleted, wrEngineIdle;
  logic        rdCmdValid, rdCmdReady, rdCmdCompleted, rdEngineIdle, doneIrq, errIrq;
  int          miscompares = 0, checks_done = 0;
  logic [15:0] rwOff [3] = '{16'h0004, 16'h000C, 16'h0010};
  tgmc_word_t  rwMask [3] = '{`TGMC_SCTRL_MASK, `TGMC_EEN_MASK, `TGMC_ERR_MASK};
  tgmc_word_t  ent [2][4];
  int          wrDoneSeen = 0;

  assign hready = hreadyout;
  always #50 sys_clk = ~sys_clk;

  tgmc_top #(.MASTER_ID_BITS(IDB), .REVISION(CORE_REVISION_FIELD)) tgmc_top_inst (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hreadyout, .hresp, .hrdata,
    .wrCmdValid, .wrCmdReady, .wrCmdData,
    .wrCmdCompleted, .wrEngineIdle, .rdCmdValid, .rdCmdReady, .rdCmdData, .rdCmdCompleted, .rdEngineIdle,
    .errEvent, .doneIrq, .errIrq);
  tgmc_engine_model tgmc_engine_model_wr_inst (.sys_clk, .rst, .cmdValid(wrCmdValid), .cmdReady(wrCmdReady),
    .cmdCompleted(wrCmdCompleted), .engineIdle(wrEngineIdle), .cmdCount(wrCount));
  tgmc_engine_model tgmc_engine_model_rd_inst (.sys_clk, .rst, .cmdValid(rdCmdValid), .cmdReady(rdCmdReady),
    .cmdCompleted(rdCmdCompleted), .engineIdle(rdEngineIdle), .cmdCount(rdCount));

  function automatic tgmc_word_t mctrl(input logic run, input logic loopOn);
    return {CORE_REVISION_FIELD, 3'(IDB <= 1 ? 0 : IDB - 1), run, loopOn, 19'h0};
  endfunction : mctrl

  task automatic report_and_stop();
    if (miscompares == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string name, input tgmc_word_t expv, input tgmc_word_t got);
    checks_done++;
    if (got !== expv)
    begin
      $display("[ERR] %s expected %h seen %h", name, expv, got);
      miscompares++;
    end
  endtask : chk

  // Called right after a rising edge; returns at the edge that ends the data phase.
  task automatic bus(input logic wr, input logic [15:0] a, input tgmc_word_t wd, output tgmc_word_t rd,
                     output logic err);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge sys_clk iff hreadyout === 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? wd : ~hwdata;
    err = 1'b0;
    do
    begin
      @(posedge sys_clk);
      err = err | hresp;
    end
    while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [15:0] a, input tgmc_word_t d);
    tgmc_word_t r;
    logic       e;
    bus(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input string name, input logic [15:0] a, input tgmc_word_t expv, input logic expErr);
    tgmc_word_t r;
    logic       e;
    bus(1'b0, a, '0, r, e);
    chk({name, "_resp"}, {31'h0, expErr}, {31'h0, e});
    if (!expErr)
      chk(name, expv, r);
  endtask : rd

  task automatic fill(input logic [15:0] base, input int n);
    for (int i = 0; i < n; i++)
    begin
      ent[base[13]][i] = {4'h8, 28'($urandom)};
      wr(base + 16'(4 * i), ent[base[13]][i]);
    end
    wr(base + 16'(4 * n), 32'h0);
  endtask : fill

  task automatic wait_done();
    for (int i = 0; i < 4000; i++)
    begin
      @(posedge sys_clk);
      if (doneIrq === 1'b1)
        break;
    end
  endtask : wait_done

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Every run starts at entry 0 and takes whole sets, so the take count gives the entry index.
  always @(posedge sys_clk)
  begin
    if (wrCmdValid === 1'b1 && wrCmdReady === 1'b1)
      chk("wr_data", ent[0][wrCount % 3], wrCmdData);
    if (rdCmdValid === 1'b1 && rdCmdReady === 1'b1)
      chk("rd_data", ent[1][rdCount % 2], rdCmdData);
    if (rdCmdValid === 1'b1 && rdCmdReady === 1'b1 && rdCount == 16'd1)
      chk("rd_dep", 32'h1, {31'h0, wrDoneSeen >= 3});
    if (wrCmdCompleted === 1'b1)
      wrDoneSeen++;
  end

  initial
  begin
    repeat (60000) @(posedge sys_clk);
    miscompares++;
    report_and_stop();
  end

  initial
  begin
    tgmc_word_t d, m, r;
    logic       e;
    void'($urandom(77));
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd("mctrl_reset", 16'h0000, mctrl(1'b0, 1'b0), 1'b0);
    rd("sctrl_reset", 16'h0004, 32'h0, 1'b0);
    rd("estat_reset", 16'h0008, 32'h0, 1'b0);
    rd("eenable_reset", 16'h000C, 32'h80000000, 1'b0);
    rd("emask_reset", 16'h0010, 32'h0, 1'b0);
    rd("config", 16'h0014, CFG, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      d = $urandom;
      wr(rwOff[i], d);
      rd("rw_back", rwOff[i], d & rwMask[i], 1'b0);
    end
    wr(16'h0000, $urandom & 32'hFFE7FFFF);
    rd("mctrl_ro", 16'h0000, mctrl(1'b0, 1'b0), 1'b0);
    for (int a = 16'h18; a <= 16'h2C; a += 4)
    begin
      wr(16'(a), $urandom);
      rd("reserved", 16'(a), 32'h0, 1'b0);
    end
    bus(1'b1, 16'h00B4, $urandom, r, e);
    chk("probe_wr_resp", 32'h1, {31'h0, e});
    rd("probe_rd", 16'h00B4, 32'h0, 1'b1);
    wr(16'h000C, 32'h801F0003);
    m = $urandom & `TGMC_ERR_MASK;
    wr(16'h0010, m);
    d = ($urandom & `TGMC_ERR_MASK) | 32'h1;
    errEvent <= d;
    @(posedge sys_clk);
    errEvent <= '0;
    rd("estat_set", 16'h0008, d, 1'b0);
    chk("err_irq", {31'h0, |(d & m)}, {31'h0, errIrq});
    wr(16'h0008, d);
    rd("estat_w1c", 16'h0008, 32'h0, 1'b0);
    fill(16'h1000, 3);
    fill(16'h2000, 2);
    ent[1][1] = 32'hA0000002;
    wr(16'h2004, ent[1][1]);
    wr(16'h0000, 32'h00100000);
    rd("run_set", 16'h0000, mctrl(1'b1, 1'b0), 1'b0);
    wait_done();
    chk("done_irq", 32'h1, {31'h0, doneIrq});
    rd("run_clear", 16'h0000, mctrl(1'b0, 1'b0), 1'b0);
    chk("wr_cmds", 32'd3, {16'h0, wrCount});
    chk("rd_cmds", 32'd2, {16'h0, rdCount});
    rd("estat_done", 16'h0008, 32'h80000000, 1'b0);
    wr(16'h0008, 32'h80000000);
    wr(16'h0000, 32'h00180000);
    repeat (300) @(posedge sys_clk);
    chk("loop_wr", 32'h1, {31'h0, wrCount > 16'd20});
    chk("loop_rd", 32'h1, {31'h0, rdCount > 16'd20});
    chk("loop_no_irq", 32'h0, {31'h0, doneIrq});
    rd("loop_run", 16'h0000, mctrl(1'b1, 1'b1), 1'b0);
    wr(16'h0000, 32'h0);
    wait_done();
    chk("final_wr_set", 32'h0, {16'h0, wrCount % 16'd3});
    chk("final_rd_set", 32'h0, {16'h0, rdCount % 16'd2});
    rd("loop_end", 16'h0000, mctrl(1'b0, 1'b0), 1'b0);
    wr(16'h0008, 32'h80000000);
    wr(16'h000C, 32'h0);
    wr(16'h0000, 32'h00100000);
    for (int i = 0; i < 100; i++)
    begin
      bus(1'b0, 16'h0000, '0, r, e);
      if (r[20] === 1'b0)
        break;
    end
    chk("gated_irq", 32'h0, {31'h0, doneIrq});
    rd("gated_estat", 16'h0008, 32'h0, 1'b0);
    rd("gated_run", 16'h0000, mctrl(1'b0, 1'b0), 1'b0);
    report_and_stop();
  end
endmodule : tb_tgmc_top

`default_nettype wire
